// [core/panel_vt_cfg.svh]
/*
 Constants for the panel vertical timing extension block: register
 indices, writable masks, reset values and field positions.
 Assumes it is included by bare name under core/.
*/
`ifndef PANEL_VT_CFG_SVH
`define PANEL_VT_CFG_SVH

// ----------------------------------------
// Register indices on the data port
// ----------------------------------------
`define IDX_VERT_TOTAL_LOW      8'hb0
`define IDX_VERT_EXTENSION      8'hb1
`define IDX_SIMUL_VSYNC_START   8'hb2
`define IDX_SIMUL_VSYNC_END     8'hb3
`define IDX_PANEL_VSIZE_LOW     8'hbb
`define IDX_PANEL_VSIZE_INCR    8'hbc
`define IDX_FRAME_START_POS     8'hbd
`define IDX_PANEL_VERT_EXT      8'hbe

// ----------------------------------------
// Writable bit masks, reserved bits zero
// ----------------------------------------
`define MASK_VERT_EXTENSION     8'h9f
`define MASK_SIMUL_VSYNC_END    8'h0f
`define MASK_PANEL_VERT_EXT     8'hdb
`define RESET_REG               8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VEXT_SENSE_ASSIST       7
`define VEXT_VCLK_ON_ROM        2
`define PEXT_CLUT_DLY_HI        7
`define PEXT_CLUT_DLY_LO        6

// ----------------------------------------
// Timing counts in scanlines and clocks
// ----------------------------------------
`define FRAME_EXTRA_LINES       10'h002
`define PANEL_EXTRA_LINES       10'h002
`define CLUT_MAX_DELAY          3

`endif

// [core/panel_vt_pkg.sv]
/*
 Types for the panel vertical timing extension block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package panel_vt_pkg;
    // Display output mode
    typedef enum logic [1:0] {
        MODE_CRT_ONLY,
        MODE_PANEL_ONLY,
        MODE_SIMUL
    } disp_mode_t;

    // Read pulse delay codes
    typedef enum logic [1:0] {
        DLY_TWO   = 2'h0,
        DLY_ONE   = 2'h1,
        DLY_THREE = 2'h2,
        DLY_NONE  = 2'h3
    } clut_dly_t;
endpackage

// [core/vert_line_counter.sv]
/*
 Scanline counter: counts line ticks from zero up to a last line, then
 wraps and flags the frame start.
 Assumes one lineTick pulse per scanline from the horizontal timing.
*/
`timescale 1ns/10ps
`default_nettype none

module vert_line_counter #(
    parameter int W = 10
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         lineTick,
    input  wire logic [W-1:0] lastLine,
    output logic      [W-1:0] lineCnt_r,
    output logic              frameWrap_r
);
    logic [W-1:0] lineCnt_nxt;   // Next line number
    logic         frameWrap_nxt; // Next wrap flag

    // Next count, wrapping after the last line
    always_comb begin
        lineCnt_nxt   = lineCnt_r;
        frameWrap_nxt = 1'b0;
        if (lineTick) begin
            if (lineCnt_r >= lastLine) begin
                lineCnt_nxt   = '0;
                frameWrap_nxt = 1'b1;
            end else begin
                lineCnt_nxt = lineCnt_r + 1'b1;
            end
        end
    end

    // Count registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lineCnt_r   <= '0;
            frameWrap_r <= 1'b0;
        end else begin
            lineCnt_r   <= lineCnt_nxt;
            frameWrap_r <= frameWrap_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_line_wrap: assert property (lineTick && lineCnt_r == lastLine |=> lineCnt_r == '0 && frameWrap_r)
        else $error("line counter did not wrap at last line");
endmodule

`default_nettype wire

// [core/clut_pulse_delay.sv]
/*
 Read pulse delay for the graphics lookup table: delays a request by
 a selectable number of clocks, then registers it.
 Assumes the request is a one-cycle pulse in the ref_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module clut_pulse_delay (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       readReq,
    input  wire logic [1:0] dlyCode,
    output logic            readPulse_r
);
    logic [2:0] stage_r;      // Delay taps
    logic [2:0] stage_nxt;
    logic       readPulse_nxt;

    // Tap select by delay code
    always_comb begin
        stage_nxt = {stage_r[1:0], readReq};
        case (panel_vt_pkg::clut_dly_t'(dlyCode))
            panel_vt_pkg::DLY_NONE:  readPulse_nxt = readReq;
            panel_vt_pkg::DLY_ONE:   readPulse_nxt = stage_r[0];
            panel_vt_pkg::DLY_TWO:   readPulse_nxt = stage_r[1];
            panel_vt_pkg::DLY_THREE: readPulse_nxt = stage_r[2];
            default:                 readPulse_nxt = 1'b0;
        endcase
    end

    // Tap registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage_r     <= '0;
            readPulse_r <= 1'b0;
        end else begin
            stage_r     <= stage_nxt;
            readPulse_r <= readPulse_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_clut_two_dly: assert property (readReq && dlyCode == 2'h0 && $stable(dlyCode)[*1] ##1 dlyCode == 2'h0 ##1 dlyCode == 2'h0
                                     |=> readPulse_r)
        else $error("two-clock read pulse delay wrong");
    a_clut_no_dly: assert property (readReq && dlyCode == 2'h3 |=> readPulse_r)
        else $error("undelayed read pulse missing");
    c_clut_three: cover property (readReq && dlyCode == 2'h2 ##4 readPulse_r);
endmodule

`default_nettype wire

// [core/panel_vertical_timing_ext.sv]
/*
 Panel vertical timing extension: indexed register file plus the
 vertical timing it steers (frame length, CRT vsync in simultaneous
 mode, panel display window, frame start, clock routing, CLUT delay).
 Assumes host index/data strobes, a lineTick per scanline and the
 standard CRT values all synchronous to ref_clk.
*/
//
// Function
// - Vertical total is ten bits, split high/low
// - Extended total used only with panel enabled
// - Frame lasts programmed total plus two lines
// - Sense assist forces CRT display in simultaneous
// - Simultaneous CRT timing follows panel counter
// - Clock-out disable bit stops video clock
// - Routed clock drives boot ROM pin
// - Simultaneous vsync starts at ten-bit line
// - Sync end field sets vsync width
// - CRT-only sync end uses register field too
// - Panel vertical size is ten bits
// - Panel shows size plus two lines
// - Size increment adds lines to panel
// - Position measured from midpoint or first
// - Frame placed relative to frame start
// - CLUT read pulse delay by two bits
// - CRT-only mode uses standard vertical total
`timescale 1ns/10ps
`default_nettype none
`include "panel_vt_cfg.svh"

module panel_vertical_timing_ext (
    input  wire logic       ref_clk,             // 250 MHz clock
    input  wire logic       nrst,                // Async reset
    input  wire logic       idxWrite,            // Index port write
    input  wire logic       dataWrite,           // Data port write
    input  wire logic       dataRead,            // Data port read
    input  wire logic [7:0] busWData,            // Write data
    output logic      [7:0] busRData_r,          // Read data
    input  wire logic       panelEnable,         // Panel enable
    input  wire logic       crtEnable,           // CRT enable
    input  wire logic       senseAssistGate,     // Sense assist gate
    input  wire logic       vclkOutDisable,      // Video clock off
    input  wire logic       romPresent,          // Boot ROM strapped
    input  wire logic       panelIsDstn,         // Dual-scan panel
    input  wire logic [9:0] stdVertTotal,        // Standard total
    input  wire logic [9:0] stdVsyncStart,       // Standard vsync start
    input  wire logic [3:0] stdVsyncEnd,         // Standard vsync end
    input  wire logic       lineTick,            // One per scanline
    input  wire logic       videoClockIn,        // Video clock level
    input  wire logic       clutReadReq,         // CLUT read request
    output logic            panelFrameStart_r,   // Frame start pulse
    output logic            panelLineClock_r,    // Line clock, DSTN
    output logic            panelDisplayEnable_r,// Display enable, TFT
    output logic            crtVsync_r,          // CRT vertical sync
    output logic            forceCrtDisplay_r,   // Forced CRT display
    output logic            videoClockOut_r,     // Video clock pin
    output logic            bootRomSelectOut_r,  // ROM select pin level
    output logic            bootRomSelectOe_n_r, // ROM select enable
    output logic            clutReadPulse_r      // Delayed read pulse
);
    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] index_r, index_nxt;                          // Index
    logic [7:0] vertTotalLow_r, vertTotalLow_nxt;            // Total low
    logic [7:0] vertExtension_r, vertExtension_nxt;          // Extension
    logic [7:0] vsyncStartLow_r, vsyncStartLow_nxt;          // Vsync start
    logic [7:0] vsyncEnd_r, vsyncEnd_nxt;                    // Vsync end
    logic [7:0] panelSizeLow_r, panelSizeLow_nxt;            // Size low
    logic [7:0] panelSizeIncr_r, panelSizeIncr_nxt;          // Increment
    logic [7:0] framePosLow_r, framePosLow_nxt;              // Position
    logic [7:0] panelVertExt_r, panelVertExt_nxt;            // Panel ext
    logic [7:0] busRData_nxt;

    // Read mux by index, unmapped reads zero
    function automatic logic [7:0] readMux(input logic [7:0] idx);
        case (idx)
            `IDX_VERT_TOTAL_LOW:    readMux = vertTotalLow_r;
            `IDX_VERT_EXTENSION:    readMux = vertExtension_r;
            `IDX_SIMUL_VSYNC_START: readMux = vsyncStartLow_r;
            `IDX_SIMUL_VSYNC_END:   readMux = vsyncEnd_r;
            `IDX_PANEL_VSIZE_LOW:   readMux = panelSizeLow_r;
            `IDX_PANEL_VSIZE_INCR:  readMux = panelSizeIncr_r;
            `IDX_FRAME_START_POS:   readMux = framePosLow_r;
            `IDX_PANEL_VERT_EXT:    readMux = panelVertExt_r;
            default:                readMux = 8'h00;
        endcase
    endfunction

    // Register writes, reserved bits masked
    always_comb begin
        index_nxt         = idxWrite ? busWData : index_r;
        vertTotalLow_nxt  = vertTotalLow_r;
        vertExtension_nxt = vertExtension_r;
        vsyncStartLow_nxt = vsyncStartLow_r;
        vsyncEnd_nxt      = vsyncEnd_r;
        panelSizeLow_nxt  = panelSizeLow_r;
        panelSizeIncr_nxt = panelSizeIncr_r;
        framePosLow_nxt   = framePosLow_r;
        panelVertExt_nxt  = panelVertExt_r;
        busRData_nxt      = dataRead ? readMux(index_r) : busRData_r;
        if (dataWrite) begin
            case (index_r)
                `IDX_VERT_TOTAL_LOW:    vertTotalLow_nxt  = busWData;
                `IDX_VERT_EXTENSION:    vertExtension_nxt = busWData & `MASK_VERT_EXTENSION;
                `IDX_SIMUL_VSYNC_START: vsyncStartLow_nxt = busWData;
                `IDX_SIMUL_VSYNC_END:   vsyncEnd_nxt      = busWData & `MASK_SIMUL_VSYNC_END;
                `IDX_PANEL_VSIZE_LOW:   panelSizeLow_nxt  = busWData;
                `IDX_PANEL_VSIZE_INCR:  panelSizeIncr_nxt = busWData;
                `IDX_FRAME_START_POS:   framePosLow_nxt   = busWData;
                `IDX_PANEL_VERT_EXT:    panelVertExt_nxt  = busWData & `MASK_PANEL_VERT_EXT;
                default:                ;  // Unmapped writes dropped
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            index_r         <= `RESET_REG;
            vertTotalLow_r  <= `RESET_REG;
            vertExtension_r <= `RESET_REG;
            vsyncStartLow_r <= `RESET_REG;
            vsyncEnd_r      <= `RESET_REG;
            panelSizeLow_r  <= `RESET_REG;
            panelSizeIncr_r <= `RESET_REG;
            framePosLow_r   <= `RESET_REG;
            panelVertExt_r  <= `RESET_REG;
            busRData_r      <= `RESET_REG;
        end else begin
            index_r         <= index_nxt;
            vertTotalLow_r  <= vertTotalLow_nxt;
            vertExtension_r <= vertExtension_nxt;
            vsyncStartLow_r <= vsyncStartLow_nxt;
            vsyncEnd_r      <= vsyncEnd_nxt;
            panelSizeLow_r  <= panelSizeLow_nxt;
            panelSizeIncr_r <= panelSizeIncr_nxt;
            framePosLow_r   <= framePosLow_nxt;
            panelVertExt_r  <= panelVertExt_nxt;
            busRData_r      <= busRData_nxt;
        end
    end

    // ----------------------------------------
    // Field assembly and mode
    // ----------------------------------------
    panel_vt_pkg::disp_mode_t mode;   // Current output mode
    logic [9:0] extVertTotal;         // Ten-bit extended total
    logic [9:0] usedVertTotal;        // Total in force
    logic [9:0] lastLine;             // Final line number of frame
    logic [9:0] vsyncStart;           // Vsync start line in force
    logic [3:0] vsyncEnd;             // Vsync end field in force
    logic [9:0] panelSize;            // Ten-bit panel size
    logic [9:0] framePos;             // Frame position from start
    logic [9:0] winStart;             // Display window first line
    logic [9:0] winLines;             // Display window length
    logic [9:0] lineCnt;              // Shared scanline count
    logic       frameWrap;            // Counter wrapped

    always_comb begin
        if (panelEnable && crtEnable) begin
            mode = panel_vt_pkg::MODE_SIMUL;
        end else if (panelEnable) begin
            mode = panel_vt_pkg::MODE_PANEL_ONLY;
        end else begin
            mode = panel_vt_pkg::MODE_CRT_ONLY;
        end
        extVertTotal  = {vertExtension_r[1:0], vertTotalLow_r};
        usedVertTotal = panelEnable ? extVertTotal : stdVertTotal;
        lastLine      = usedVertTotal + `FRAME_EXTRA_LINES - 10'h001;
        vsyncStart    = (mode == panel_vt_pkg::MODE_SIMUL)
                      ? {vertExtension_r[4:3], vsyncStartLow_r} : stdVsyncStart;
        vsyncEnd      = vsyncEnd_r[3:0];
        panelSize     = {panelVertExt_r[4:3], panelSizeLow_r};
        framePos      = {panelVertExt_r[1:0], framePosLow_r};
        // Dual-scan counts from the midpoint, TFT from the first line
        winStart      = (panelIsDstn ? {1'b0, lastLine[9:1]} : 10'h000) + framePos;
        winLines      = panelSize + `PANEL_EXTRA_LINES + {2'h0, panelSizeIncr_r};
    end

    // ----------------------------------------
    // Scanline counter, one for both displays
    // ----------------------------------------
    vert_line_counter #(
        .W (10)
    ) u_lineCounter (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .lineTick    (lineTick),
        .lastLine    (lastLine),
        .lineCnt_r   (lineCnt),
        .frameWrap_r (frameWrap)
    );

    // ----------------------------------------
    // Timing outputs
    // ----------------------------------------
    logic inWindow;                   // Line inside panel window
    logic panelFrameStart_nxt, panelLineClock_nxt, panelDisplayEnable_nxt;
    logic crtVsync_nxt, forceCrtDisplay_nxt, videoClockOut_nxt;
    logic bootRomSelectOut_nxt, bootRomSelectOe_n_nxt;

    always_comb begin
        inWindow = (lineCnt >= winStart) && ((lineCnt - winStart) < winLines);
        panelFrameStart_nxt    = frameWrap;
        panelLineClock_nxt     = panelIsDstn && lineTick && inWindow;
        panelDisplayEnable_nxt = !panelIsDstn && inWindow;
        // Vsync opens at the start line, closes on low-bit match
        crtVsync_nxt = crtVsync_r;
        if (lineTick) begin
            if (lineCnt == vsyncStart) begin
                crtVsync_nxt = 1'b1;
            end else if (crtVsync_r && lineCnt[3:0] == vsyncEnd) begin
                crtVsync_nxt = 1'b0;
            end
        end
        forceCrtDisplay_nxt = (mode == panel_vt_pkg::MODE_SIMUL) && senseAssistGate
                            && vertExtension_r[`VEXT_SENSE_ASSIST];
        videoClockOut_nxt   = videoClockIn && !vclkOutDisable;
        if (vertExtension_r[`VEXT_VCLK_ON_ROM] && !romPresent) begin
            bootRomSelectOut_nxt  = videoClockOut_nxt;
            bootRomSelectOe_n_nxt = 1'b0;
        end else begin
            bootRomSelectOut_nxt  = 1'b0;
            bootRomSelectOe_n_nxt = 1'b1;
        end
    end

    // Timing output flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            panelFrameStart_r    <= 1'b0;
            panelLineClock_r     <= 1'b0;
            panelDisplayEnable_r <= 1'b0;
            crtVsync_r           <= 1'b0;
            forceCrtDisplay_r    <= 1'b0;
            videoClockOut_r      <= 1'b0;
            bootRomSelectOut_r   <= 1'b0;
            bootRomSelectOe_n_r  <= 1'b1;
        end else begin
            panelFrameStart_r    <= panelFrameStart_nxt;
            panelLineClock_r     <= panelLineClock_nxt;
            panelDisplayEnable_r <= panelDisplayEnable_nxt;
            crtVsync_r           <= crtVsync_nxt;
            forceCrtDisplay_r    <= forceCrtDisplay_nxt;
            videoClockOut_r      <= videoClockOut_nxt;
            bootRomSelectOut_r   <= bootRomSelectOut_nxt;
            bootRomSelectOe_n_r  <= bootRomSelectOe_n_nxt;
        end
    end

    // ----------------------------------------
    // CLUT read pulse delay
    // ----------------------------------------
    clut_pulse_delay u_clutDelay (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .readReq     (clutReadReq),
        .dlyCode     (panelVertExt_r[`PEXT_CLUT_DLY_HI:`PEXT_CLUT_DLY_LO]),
        .readPulse_r (clutReadPulse_r)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_total_panel_sel: assert property (panelEnable |-> lastLine == {vertExtension_r[1:0], vertTotalLow_r} + 10'h001)
        else $error("extended total not used with panel on");
    a_total_crt_sel: assert property (!panelEnable |-> lastLine == stdVertTotal + 10'h001)
        else $error("standard total not used in CRT-only mode");
    a_sense_force: assert property (panelEnable && crtEnable && senseAssistGate && vertExtension_r[7]
                                    |=> forceCrtDisplay_r)
        else $error("sense assist did not force CRT display");
    a_vclk_off: assert property (vclkOutDisable |=> !videoClockOut_r)
        else $error("video clock out not disabled");
    a_rom_route: assert property (vertExtension_r[2] && !romPresent |=> !bootRomSelectOe_n_r
                                  && bootRomSelectOut_r == videoClockOut_r)
        else $error("video clock not routed to ROM pin");
    a_vsync_open: assert property (lineTick && panelEnable && crtEnable && !crtVsync_r
                                   && lineCnt == {vertExtension_r[4:3], vsyncStartLow_r} |=> crtVsync_r)
        else $error("simultaneous vsync did not start");
    a_vsync_close: assert property (lineTick && crtVsync_r && lineCnt != vsyncStart
                                    && lineCnt[3:0] == vsyncEnd_r[3:0] |=> !crtVsync_r)
        else $error("vsync did not end at sync end field");
    a_reserved_read: assert property (dataRead && index_r == `IDX_SIMUL_VSYNC_END |=> busRData_r[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    a_tft_window: assert property (!panelIsDstn && lineCnt == framePos && winLines != 10'h000
                                   |=> panelDisplayEnable_r)
        else $error("panel window did not open at position");

    c_simul_vsync: cover property (panelEnable && crtEnable && crtVsync_r);
    c_frame_start: cover property (panelFrameStart_r ##[1:20] panelDisplayEnable_r);
    c_rom_clock:   cover property (!bootRomSelectOe_n_r && bootRomSelectOut_r);
endmodule

`default_nettype wire

// [verif/panel_display_model.sv]
/* Display-side model: makes line ticks and a video clock, and
   counts lines per frame at the panel and CRT outputs.
   Assumes the timing block's outputs are on ref_clk. */
`timescale 1ns/10ps
`default_nettype none
module panel_display_model (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       frameStart,
    input  wire logic       dispEn,
    input  wire logic       vsync,
    output logic            lineTick,
    output logic            vclk,
    output logic      [9:0] frameLines,
    output logic      [9:0] deLines,
    output logic      [9:0] vsLines
);
    // ----------------------------------------
    // Line source and per-frame counts
    // ----------------------------------------
    logic [1:0] div = 2'h0;              // Tick every fourth clock
    logic [9:0] nL, nD, nV;              // Running counts
    initial lineTick = 1'b0;
    initial vclk = 1'b0;
    // Sources change off the falling edge
    always @(negedge ref_clk) begin
        div <= nrst ? div + 2'h1 : 2'h0;
        lineTick <= nrst && (div == 2'h3);
        vclk <= ~vclk;
    end
    // Latch counts at each frame start
    always @(posedge ref_clk) begin
        if (frameStart) begin
            frameLines <= nL;
            deLines <= nD;
            vsLines <= nV;
            {nL, nD, nV} <= 30'h0;
        end else if (lineTick) begin
            nL <= nL + 10'h001;
            nD <= nD + {9'h0, dispEn};
            nV <= nV + {9'h0, vsync};
        end
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
/* Bench for the panel vertical timing block: register tasks on the
   index/data port, frame and pin checks. Assumes the display model. */
`timescale 1ns/10ps
`default_nettype none
`include "panel_vt_cfg.svh"
module tb;
    logic ref_clk = 0, nrst = 0, idxWrite = 0, dataWrite = 0, dataRead = 0;
    logic [7:0] busWData = 8'h00, busRData_r;
    logic panelEnable = 0, crtEnable = 0, senseAssistGate = 0, vclkOutDisable = 0;
    logic romPresent = 1, clutReadReq = 0, lineTick, videoClockIn, a, panelIsDstn = 0;
    logic fs, lc, de, vs, fc, vo, ro, oe, cp;
    logic [9:0] frameLines, deLines, vsLines;
    int bad_count = 0, checked = 0, n, m;
    int dl[4] = '{3, 2, 4, 1};           // Read pulse latency per code
    always #2 ref_clk = ~ref_clk;
    panel_vertical_timing_ext dut_u (.ref_clk(ref_clk), .nrst(nrst), .idxWrite(idxWrite),
        .dataWrite(dataWrite), .dataRead(dataRead), .busWData(busWData), .busRData_r(busRData_r),
        .panelEnable(panelEnable), .crtEnable(crtEnable), .senseAssistGate(senseAssistGate),
        .vclkOutDisable(vclkOutDisable), .romPresent(romPresent), .panelIsDstn(panelIsDstn),
        .stdVertTotal(10'h00e), .stdVsyncStart(10'h000), .stdVsyncEnd(4'h0), .lineTick(lineTick),
        .videoClockIn(videoClockIn), .clutReadReq(clutReadReq), .panelFrameStart_r(fs),
        .panelLineClock_r(lc), .panelDisplayEnable_r(de), .crtVsync_r(vs), .forceCrtDisplay_r(fc),
        .videoClockOut_r(vo), .bootRomSelectOut_r(ro), .bootRomSelectOe_n_r(oe), .clutReadPulse_r(cp));
    panel_display_model model_u (.ref_clk(ref_clk), .nrst(nrst), .frameStart(fs), .dispEn(de),
        .vsync(vs), .lineTick(lineTick), .vclk(videoClockIn), .frameLines(frameLines),
        .deLines(deLines), .vsLines(vsLines));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(negedge ref_clk) {idxWrite, busWData} = {1'b1, i};
        @(negedge ref_clk) {idxWrite, dataWrite, busWData} = {2'b01, d};
        @(negedge ref_clk) dataWrite = 0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] exp);
        @(negedge ref_clk) {idxWrite, busWData} = {1'b1, i};
        @(negedge ref_clk) {idxWrite, dataRead} = 2'b01;
        @(negedge ref_clk) dataRead = 0;
        @(negedge ref_clk) chk({2'h0, busRData_r}, {2'h0, exp});
    endtask
    // Let two full frames pass after a change
    task automatic frames();
        repeat (3) begin
            n = 0;
            do @(negedge ref_clk) n++; while (fs !== 1'b1 && n < 4000);
            chk({9'h0, fs}, 10'h001);
        end
        @(negedge ref_clk);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge ref_clk);
        nrst = 1;
        foreach (dl[k]) rd(8'hb0 + 8'(k), 8'h00);
        rd(`IDX_PANEL_VSIZE_LOW, 8'h00);
        wr(`IDX_VERT_EXTENSION, 8'hff);
        rd(`IDX_VERT_EXTENSION, 8'h9f);
        wr(`IDX_SIMUL_VSYNC_END, 8'hff);
        rd(`IDX_SIMUL_VSYNC_END, 8'h0f);
        wr(`IDX_PANEL_VERT_EXT, 8'hff);
        rd(`IDX_PANEL_VERT_EXT, 8'hdb);
        wr(8'hb5, 8'h5a);
        rd(8'hb5, 8'h00);
        wr(`IDX_VERT_TOTAL_LOW, 8'h04);
        wr(`IDX_VERT_EXTENSION, 8'h01);
        wr(`IDX_PANEL_VERT_EXT, 8'h00);
        panelEnable = 1;
        frames();
        chk(frameLines, 10'h106);
        wr(`IDX_VERT_EXTENSION, 8'h00);
        wr(`IDX_VERT_TOTAL_LOW, 8'h14);
        wr(`IDX_PANEL_VSIZE_LOW, 8'h03);
        wr(`IDX_PANEL_VSIZE_INCR, 8'h02);
        wr(`IDX_FRAME_START_POS, 8'h01);
        frames();
        chk(frameLines, 10'h016);
        chk(deLines, 10'h007);
        panelIsDstn = 1;
        wr(`IDX_PANEL_VSIZE_LOW, 8'h08);
        frames();
        {n, m} = 64'h0;
        do @(negedge ref_clk) {n, m} = {n + 1, m + int'(lc)}; while (fs !== 1'b1 && n < 4000);
        chk(10'(m), 10'h00b);
        chk(deLines, 10'h000);
        panelIsDstn = 0;
        panelEnable = 0;
        frames();
        chk(frameLines, 10'h010);
        chk(vsLines, 10'h00f);
        {panelEnable, crtEnable} = 2'b11;
        wr(`IDX_SIMUL_VSYNC_START, 8'h02);
        wr(`IDX_SIMUL_VSYNC_END, 8'h07);
        frames();
        chk(vsLines, 10'h005);
        wr(`IDX_VERT_EXTENSION, 8'h80);
        chk({9'h0, fc}, 10'h000);
        senseAssistGate = 1;
        repeat (2) @(negedge ref_clk);
        chk({9'h0, fc}, 10'h001);
        wr(`IDX_VERT_EXTENSION, 8'h04);
        romPresent = 0;
        repeat (2) @(negedge ref_clk);
        chk({9'h0, fc}, 10'h000);
        chk({9'h0, oe}, 10'h000);
        chk({9'h0, ro ^ vo}, 10'h000);
        a = vo;
        @(negedge ref_clk) chk({9'h0, a ^ vo}, 10'h001);
        {romPresent, vclkOutDisable} = 2'b11;
        repeat (3) @(negedge ref_clk);
        chk({9'h0, oe}, 10'h001);
        repeat (2) @(negedge ref_clk) chk({9'h0, vo}, 10'h000);
        for (int c = 0; c < 4; c++) begin
            wr(`IDX_PANEL_VERT_EXT, {2'(c), 6'h00});
            @(negedge ref_clk) clutReadReq = 1;
            n = 0;
            do @(negedge ref_clk) {clutReadReq, n} = {1'b0, n + 1}; while (cp !== 1'b1 && n < 8);
            chk(10'(n), 10'(dl[c]));
        end
        summarize();
    end
endmodule
`default_nettype wire
